/* spsc_defines.svh */
`ifndef SPSC_DEFINES_SVH
`define SPSC_DEFINES_SVH
// APB byte addresses.
`define SPSC_A_CTRL 8'h00
`define SPSC_A_TMO 8'h04
`define SPSC_A_BEEP 8'h08
`define SPSC_A_CMD 8'h0C
`define SPSC_A_STAT 8'h10
`define SPSC_A_ERR 8'h14
`define SPSC_A_TPER 8'h18
// Field positions.
`define SPSC_CTRL_RST 3
`define SPSC_CMD_TONE 0
`define SPSC_CMD_VOL 1
`define SPSC_CMD_TEST 2
`define SPSC_ST_ERR 9
// Synchroniser lanes.
`define SPSC_P_MOT 0
`define SPSC_P_BTN 1
`define SPSC_P_ZU 2
`define SPSC_P_ZR 3
// Reset and default values.
`define SPSC_TMO_DEF 16'h0384
`define SPSC_TPER_DEF 16'h0E10
`define SPSC_TONE_DEF 3'h3
`define SPSC_VOL_DEF 2'h2
`define SPSC_CAL_PTS 3'h5
// Times: clock period and one millisecond in ns.
`define SPSC_CLK_NS 4
`define SPSC_MS_NS 1000000
// Times in milliseconds or seconds.
`define SPSC_MS_PER_S 10'h3E8
`define SPSC_LONG_MS 12'hBB8
`define SPSC_BLINK_MS 12'h1F4
`define SPSC_TONE_MS 12'h064
`define SPSC_GAP_MS 12'h12C
`define SPSC_DUAL_S 16'h0708
`endif

/* spsc_pkg.sv */
package spsc_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } spsc_apb_t;
  typedef enum logic [2:0] {
    PS_START = 3'h0, PS_RUN = 3'h1, PS_BLINK = 3'h2,
    PS_LOFF = 3'h3, PS_ALLOFF = 3'h4
  } spsc_ps_t;
  typedef enum logic [2:0] {
    BP_IDLE = 3'h0, BP_NEW = 3'h1, BP_GAP = 3'h2,
    BP_C1 = 3'h3, BP_SP = 3'h4, BP_C2 = 3'h5
  } spsc_bp_t;
  typedef enum logic [2:0] {
    MD_BLINK = 3'h1, MD_LOFF = 3'h2, MD_LMOFF = 3'h3,
    MD_DUAL1 = 3'h4, MD_DUAL2 = 3'h5
  } spsc_mode_t;
endpackage

/* spsc_top.sv */
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "spsc_defines.svh"
module spsc_top #(
  parameter int MS_CYCLES = `SPSC_MS_NS / `SPSC_CLK_NS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire spsc_pkg::spsc_apb_t apb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic decode_ok,
  input wire logic cal_code_ok,
  input wire logic motion_detector,
  input wire logic vol_button,
  input wire logic zero_button,
  input wire logic remote_zero_button,
  input wire logic scale_at_zero,
  input wire logic test_done,
  input wire logic test_fail,
  input wire logic [7:0] test_code,
  output logic laser_on,
  output logic motor_on,
  output logic test_start,
  output logic beep_on,
  output logic beep_error,
  output logic [2:0] beep_tone,
  output logic [1:0] beep_volume,
  output logic led_white,
  output logic led_blue,
  output logic led_amber,
  output logic zero_req,
  output logic cal_store,
  output logic [2:0] cal_point
);
  import spsc_pkg::*;

  localparam logic [19:0] MS_LAST = 20'(MS_CYCLES - 1);

  spsc_ps_t ps;
  spsc_mode_t mode;
  spsc_bp_t bp;
  spsc_bp_t next_bp;
  logic [19:0] ms_cnt;
  logic ms_tick;
  logic [9:0] ms_in_s;
  logic sec_tick;
  logic [3:0] sync1, sync2, pin_d, rise;
  logic [15:0] tmo, tper, idle_s, dual_s, per_s;
  logic [11:0] hold_ms, blk_ms, bp_ms, bp_lim;
  logic blink_ph, btn_used, cal_act, st_go, st_ph, err;
  logic bp_full_r, bp_go, bp_full, bp_err, bp_end;
  logic [7:0] err_code;
  logic wr, setup, mapped, restore;
  logic cmd_tone, cmd_vol, cmd_test;
  logic btn_lvl, btn_rise, btn_fall, mot_rise;
  logic long_hit, short_rel, activity, dual_due, per_due;
  logic st_beep, run_err;
  logic [31:0] rdata;
  spsc_ps_t sleep_state;

  // Bus strobes and command pulses.
  assign setup = apb.psel && !apb.penable;
  assign wr = apb.psel && apb.penable && apb.pwrite && pready;
  assign restore = wr && apb.paddr == `SPSC_A_CTRL &&
                   apb.pwdata[`SPSC_CTRL_RST];
  assign cmd_tone = wr && apb.paddr == `SPSC_A_CMD &&
                    apb.pwdata[`SPSC_CMD_TONE];
  assign cmd_vol = wr && apb.paddr == `SPSC_A_CMD &&
                   apb.pwdata[`SPSC_CMD_VOL];
  assign cmd_test = wr && apb.paddr == `SPSC_A_CMD &&
                    apb.pwdata[`SPSC_CMD_TEST];

  // Read mux and address decode.
  always_comb begin
    rdata = 32'h0;
    mapped = 1'b1;
    case (apb.paddr)
      `SPSC_A_CTRL: rdata = {29'h0, mode};
      `SPSC_A_TMO: rdata = {16'h0, tmo};
      `SPSC_A_BEEP: rdata = {26'h0, beep_volume, 1'b0, beep_tone};
      `SPSC_A_CMD: rdata = 32'h0;
      `SPSC_A_STAT: rdata = {22'h0, err, cal_act, cal_point, ps,
                             laser_on, motor_on};
      `SPSC_A_ERR: rdata = {24'h0, err_code};
      `SPSC_A_TPER: rdata = {16'h0, tper};
      default: mapped = 1'b0;
    endcase
  end

  // Answer every transfer in its first access cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !apb.pwrite) ? rdata : 32'h0;
    end
  end

  // Millisecond and second ticks.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ms_cnt <= 20'h0;
      ms_tick <= 1'b0;
      ms_in_s <= 10'h0;
      sec_tick <= 1'b0;
    end else begin
      ms_tick <= ms_cnt == MS_LAST;
      ms_cnt <= (ms_cnt == MS_LAST) ? 20'h0 : ms_cnt + 20'h1;
      sec_tick <= ms_tick && ms_in_s == `SPSC_MS_PER_S - 10'h1;
      if (ms_tick) begin
        ms_in_s <= (ms_in_s == `SPSC_MS_PER_S - 10'h1) ? 10'h0 :
                   ms_in_s + 10'h1;
      end
    end
  end

  // Two-stage synchronisers for the pins, then a third stage for edges.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      pin_d <= 4'h0;
    end else begin
      sync1 <= {remote_zero_button, zero_button, vol_button,
                motion_detector};
      sync2 <= sync1;
      pin_d <= sync2;
    end
  end

  assign rise = sync2 & ~pin_d;
  assign btn_lvl = sync2[`SPSC_P_BTN];
  assign btn_rise = rise[`SPSC_P_BTN];
  assign btn_fall = !sync2[`SPSC_P_BTN] && pin_d[`SPSC_P_BTN];
  assign mot_rise = rise[`SPSC_P_MOT];
  // long hold detect: the tick past three seconds.
  assign long_hit = btn_lvl && !btn_used && ms_tick &&
                    hold_ms == `SPSC_LONG_MS;
  // short press detect: release before the long mark.
  assign short_rel = btn_fall && !btn_used && ps == PS_RUN;
  assign activity = decode_ok || mot_rise || btn_rise;
  assign dual_due = dual_s >= `SPSC_DUAL_S &&
                    (mode == MD_DUAL1 || mode == MD_DUAL2);
  assign per_due = ps != PS_START && per_s >= tper;

  // Button hold time and whether this press is already consumed.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_ms <= 12'h0;
      btn_used <= 1'b0;
    end else begin
      if (!btn_lvl) begin
        hold_ms <= 12'h0;
      end else if (ms_tick && hold_ms != 12'hFFF) begin
        hold_ms <= hold_ms + 12'h1;
      end
      if (btn_rise) begin
        btn_used <= ps != PS_RUN;
      end else if (long_hit) begin
        btn_used <= 1'b1;
      end
    end
  end

  // Configuration registers written over the bus.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode <= MD_DUAL2;
      tmo <= `SPSC_TMO_DEF;
      tper <= `SPSC_TPER_DEF;
    end else if (restore) begin
      mode <= MD_DUAL2;
      tmo <= `SPSC_TMO_DEF;
      tper <= `SPSC_TPER_DEF;
    end else if (wr) begin
      // mode select: only the five codes are kept.
      if (apb.paddr == `SPSC_A_CTRL && apb.pwdata[2:0] >= MD_BLINK &&
          apb.pwdata[2:0] <= MD_DUAL2) begin
        mode <= spsc_mode_t'(apb.pwdata[2:0]);
      end
      if (apb.paddr == `SPSC_A_TMO) begin
        tmo <= apb.pwdata[15:0];
      end
      if (apb.paddr == `SPSC_A_TPER) begin
        tper <= apb.pwdata[15:0];
      end
    end
  end

  // Tone and volume settings.
  always_ff @(posedge clk) begin
    if (!rst_n || restore) begin
      beep_tone <= `SPSC_TONE_DEF;
      beep_volume <= `SPSC_VOL_DEF;
    end else begin
      if (cmd_tone) begin
        beep_tone <= beep_tone + 3'h1;
      end else if (wr && apb.paddr == `SPSC_A_BEEP) begin
        beep_tone <= apb.pwdata[2:0];
      end
      if (cmd_vol || (short_rel && !cal_act)) begin
        beep_volume <= beep_volume + 2'h1;
      end else if (wr && apb.paddr == `SPSC_A_BEEP) begin
        beep_volume <= apb.pwdata[5:4];
      end
    end
  end

  // Sleep state that the chosen mode enters on timeout.
  always_comb begin
    unique case (mode)
      MD_BLINK, MD_DUAL1: sleep_state = PS_BLINK;
      MD_LOFF, MD_DUAL2: sleep_state = PS_LOFF;
      default: sleep_state = PS_ALLOFF;
    endcase
  end

  // Power save state machine.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ps <= PS_START;
    end else begin
      unique case (ps)
        PS_START: if (st_ph && bp == BP_IDLE) begin
          ps <= PS_RUN;
        end
        PS_RUN: if (long_hit) begin
          ps <= PS_ALLOFF;
        end else if (!activity && idle_s >= tmo) begin
          ps <= sleep_state;
        end
        PS_BLINK: if (decode_ok || btn_rise ||
                      (mot_rise && mode == MD_DUAL1)) begin
          ps <= PS_RUN;
        end else if (dual_due) begin
          ps <= PS_ALLOFF;
        end
        PS_LOFF: if (btn_rise || mot_rise) begin
          ps <= PS_RUN;
        end else if (dual_due) begin
          ps <= PS_ALLOFF;
        end
        PS_ALLOFF: if (btn_rise || mot_rise) begin
          ps <= PS_RUN;
        end
        default: ps <= PS_RUN;
      endcase
    end
  end

  // Inactivity, dual-interval and self-test period timers in seconds.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idle_s <= 16'h0;
      dual_s <= 16'h0;
      per_s <= 16'h0;
    end else begin
      if (ps != PS_RUN || activity) begin
        idle_s <= 16'h0;
      end else if (sec_tick && idle_s != 16'hFFFF) begin
        idle_s <= idle_s + 16'h1;
      end
      if (ps == PS_RUN || ps == PS_START) begin
        dual_s <= 16'h0;
      end else if (sec_tick && dual_s != 16'hFFFF) begin
        dual_s <= dual_s + 16'h1;
      end
      if (ps == PS_START || per_due) begin
        per_s <= 16'h0;
      end else if (sec_tick && per_s != 16'hFFFF) begin
        per_s <= per_s + 16'h1;
      end
    end
  end

  // Blink phase, also used to flash the white indicator.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      blk_ms <= 12'h0;
      blink_ph <= 1'b0;
    end else if (ms_tick) begin
      if (blk_ms == `SPSC_BLINK_MS - 12'h1) begin
        blk_ms <= 12'h0;
        blink_ph <= !blink_ph;
      end else begin
        blk_ms <= blk_ms + 12'h1;
      end
    end
  end

  // Laser and motor drive.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      laser_on <= 1'b0;
      motor_on <= 1'b0;
    end else begin
      laser_on <= ps == PS_RUN || (ps == PS_BLINK && blink_ph);
      motor_on <= ps != PS_ALLOFF;
    end
  end

  // Startup sequence and self-test results.
  assign st_beep = ps == PS_START && st_go && test_done && !st_ph;
  assign run_err = test_done && test_fail && ps != PS_START;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_go <= 1'b0;
      st_ph <= 1'b0;
      test_start <= 1'b0;
      err <= 1'b0;
      err_code <= 8'h0;
    end else begin
      st_go <= st_go || ps == PS_START;
      if (st_beep) begin
        st_ph <= 1'b1;
      end
      // start tests at power-up, by period or command.
      test_start <= (ps == PS_START && !st_go) || per_due || cmd_test;
      if (test_done && test_fail) begin
        err <= 1'b1;
        err_code <= test_code;
      end else if (wr && apb.paddr == `SPSC_A_STAT &&
                   apb.pwdata[`SPSC_ST_ERR]) begin
        err <= 1'b0;
      end
    end
  end

  // Beep requests, highest first.
  always_comb begin
    bp_go = 1'b0;
    bp_full = 1'b0;
    bp_err = 1'b0;
    if (st_beep) begin
      bp_go = 1'b1;
      bp_err = test_fail;
    end else if (run_err) begin
      bp_go = 1'b1;
      bp_err = 1'b1;
    end else if (cmd_tone || cmd_vol) begin
      bp_go = 1'b1;
      bp_full = 1'b1;
    end else if (short_rel) begin
      bp_go = 1'b1;
    end
  end

  // Beep sequencer: new tone, pause, two confirmations.
  always_comb begin
    bp_lim = (bp == BP_GAP) ? `SPSC_GAP_MS : `SPSC_TONE_MS;
    bp_end = ms_tick && bp_ms == bp_lim - 12'h1;
    next_bp = bp;
    unique case (bp)
      BP_IDLE: if (bp_go) next_bp = BP_NEW;
      BP_NEW: if (bp_end) next_bp = bp_full_r ? BP_GAP : BP_IDLE;
      BP_GAP: if (bp_end) next_bp = BP_C1;
      BP_C1: if (bp_end) next_bp = BP_SP;
      BP_SP: if (bp_end) next_bp = BP_C2;
      BP_C2: if (bp_end) next_bp = BP_IDLE;
      default: next_bp = BP_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bp <= BP_IDLE;
      bp_ms <= 12'h0;
      bp_full_r <= 1'b0;
      beep_on <= 1'b0;
      beep_error <= 1'b0;
    end else begin
      bp <= next_bp;
      bp_ms <= (bp != next_bp) ? 12'h0 : bp_ms + {11'h0, ms_tick};
      // full confirmation taken with the request.
      if (bp == BP_IDLE && bp_go) begin
        bp_full_r <= bp_full;
        beep_error <= bp_err;
      end
      beep_on <= next_bp == BP_NEW || next_bp == BP_C1 ||
                 next_bp == BP_C2;
    end
  end

  // Calibration without the remote display.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cal_act <= 1'b0;
      cal_point <= 3'h0;
      cal_store <= 1'b0;
    end else begin
      // start on code, store a point per press.
      cal_store <= cal_act && short_rel;
      if (cal_code_ok && ps == PS_RUN && !cal_act) begin
        cal_act <= 1'b1;
        cal_point <= 3'h0;
      end else if (cal_act && short_rel) begin
        cal_point <= cal_point + 3'h1;
        cal_act <= cal_point != `SPSC_CAL_PTS - 3'h1;
      end
    end
  end

  // Indicators and scale zero request.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      led_white <= 1'b0;
      led_blue <= 1'b0;
      led_amber <= 1'b0;
      zero_req <= 1'b0;
    end else begin
      // white flashes, then holds during the beep.
      led_white <= (ps == PS_START) ? (st_ph || blink_ph) :
                   (cal_act && blink_ph);
      led_blue <= ps != PS_START || st_ph;
      zero_req <= rise[`SPSC_P_ZU] || rise[`SPSC_P_ZR];
      led_amber <= scale_at_zero;
    end
  end

  // Checks on the behaviour above.
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_save_press;
    (ps == PS_BLINK || ps == PS_LOFF || ps == PS_ALLOFF) && btn_rise;
  endsequence
  sequence s_full_go;
    bp == BP_IDLE && bp_go && bp_full;
  endsequence

  a_mode_legal: assert property (
    mode inside {MD_BLINK, MD_LOFF, MD_LMOFF, MD_DUAL1, MD_DUAL2})
    else $error("illegal power save mode");
  a_blink_decode: assert property (
    ps == PS_BLINK && decode_ok |=> ps == PS_RUN)
    else $error("decode did not end blinking");
  a_loff_motor: assert property (
    ps == PS_LOFF ##1 ps == PS_LOFF |-> !laser_on && motor_on)
    else $error("laser off mode drive wrong");
  a_motion_wake: assert property (
    (ps == PS_LOFF || ps == PS_ALLOFF) && mot_rise |=> ps == PS_RUN)
    else $error("motion did not wake");
  a_alloff_dark: assert property (
    ps == PS_ALLOFF ##1 ps == PS_ALLOFF |-> !laser_on && !motor_on)
    else $error("all off mode still driving");
  a_restore_mode: assert property (
    restore |=> mode == MD_DUAL2)
    else $error("restore did not select dual two");
  a_full_beep: assert property (
    s_full_go |=> bp == BP_NEW && beep_on && bp_full_r)
    else $error("confirmed beep did not start");
  a_long_press: assert property (
    ps == PS_RUN && long_hit |=> ps == PS_ALLOFF)
    else $error("long press did not sleep");
  a_button_wake: assert property (
    s_save_press |=> ps == PS_RUN ##1 !short_rel)
    else $error("button did not wake cleanly");
  a_zero_req: assert property (
    rise[`SPSC_P_ZU] |=> zero_req ##1 led_amber == $past(scale_at_zero))
    else $error("zero request missing");
  a_idle_reset: assert property (
    ps == PS_RUN && activity && !long_hit |=> idle_s == 16'h0)
    else $error("activity did not restart timer");
endmodule
`default_nettype wire

/* spsc_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Far side: a self-test engine that answers the latest start pulse, and a
// listener on the beeper that counts the tones it hears.
module spsc_far_model #(
  parameter int DELAY = 3000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic test_start,
  input wire logic fail_next,
  input wire logic [7:0] code_next,
  input wire logic beep_on,
  output logic test_done,
  output logic test_fail,
  output logic [7:0] test_code,
  output logic [15:0] beep_count
);
  int cnt;
  logic beep_q;
  // Runs a self-test from the latest start pulse and reports it with a done pulse.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= 0;
      test_done <= 1'b0;
    end else begin
      test_done <= (cnt == 1);
      if (test_start) begin
        cnt <= DELAY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
  // Result lines carry the outcome only in the done cycle, so the block
  // must qualify them; otherwise they show the inverse.
  assign test_fail = test_done ? fail_next : ~fail_next;
  assign test_code = test_done ? code_next : ~code_next;
  // Counts tones by the rising edges of the beeper drive.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      beep_q <= 1'b0;
      beep_count <= 16'h0000;
    end else begin
      beep_q <= beep_on;
      if (beep_on && !beep_q) begin
        beep_count <= beep_count + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spsc_defines.svh"
module tb;
  import spsc_pkg::*;
  localparam int MS = 5;
  localparam int DEC = 0, CAL = 1, MOT = 2, BTN = 3, ZB = 4, ZR = 5;
  logic clk, rst_n, pready, pslverr, perr, test_done, test_fail;
  logic decode_ok, cal_code_ok, motion_detector, vol_button, zero_button;
  logic remote_zero_button, scale_at_zero, test_start, beep_on, beep_error;
  logic laser_on, motor_on, led_white, led_blue, led_amber, zero_req;
  logic cal_store, fail_next;
  logic [5:0] pins;
  logic [31:0] prdata, rd;
  logic [7:0] test_code, code_next;
  logic [2:0] beep_tone, cal_point;
  logic [1:0] beep_volume;
  logic [15:0] beeps;
  spsc_apb_t apb;
  int n_fail, checks;
  // Event pins of the block gathered in one vector for the drive tasks.
  assign {remote_zero_button, zero_button, vol_button} = pins[5:3];
  assign {motion_detector, cal_code_ok, decode_ok} = pins[2:0];
  spsc_top #(.MS_CYCLES(MS)) dut_u (.clk, .rst_n, .apb, .pready, .prdata,
    .pslverr, .decode_ok, .cal_code_ok, .motion_detector, .vol_button,
    .zero_button, .remote_zero_button, .scale_at_zero, .test_done,
    .test_fail, .test_code, .laser_on, .motor_on, .test_start, .beep_on,
    .beep_error, .beep_tone, .beep_volume, .led_white, .led_blue,
    .led_amber, .zero_req, .cal_store, .cal_point);
  spsc_far_model far_u (.clk, .rst_n, .test_start, .fail_next, .code_next,
    .beep_on, .test_done, .test_fail, .test_code, .beep_count(beeps));
  // Free-running clock, 4 ns period.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer; holds the request until pready is sampled high.
  // Only the watchdog ends a wait for an answer that never comes.
  task automatic apb_x(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
    @(posedge clk);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    apb <= '0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] exp);
    apb_x(1'b0, a, 32'h00000000);
    chk(nm, rd, exp);
  endtask
  task automatic pulse(input int b, input int n);
    pins[b] <= 1'b1;
    cyc(n);
    pins[b] <= 1'b0;
  endtask
  task automatic wait_laser(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && laser_on !== v; i++) @(posedge clk);
  endtask
  // Counts laser level changes over a span, for the blink checks.
  task automatic laser_flips(input int n, output int f);
    logic l;
    f = 0;
    l = laser_on;
    repeat (n) begin
      @(posedge clk);
      if (laser_on !== l) f++;
      l = laser_on;
    end
  endtask
  task automatic t_start();
    int i, f;
    logic w;
    f = 0;
    w = led_white;
    for (i = 0; i < 8000 && led_blue !== 1'b1; i++) begin
      @(posedge clk);
      if (led_white !== w) f++;
      w = led_white;
    end
    chk("white_flash", f > 0, 1);
    cyc(2);
    chk("white_held", led_white, 1);
    wait_laser(1'b1, 2000);
    chk("start_beeps", beeps, 1);
    chk("ready_motor", {led_blue, motor_on, laser_on}, 7);
  endtask
  task automatic t_regs();
    rdchk("ctrl_rst", `SPSC_A_CTRL, 5);
    rdchk("tmo_rst", `SPSC_A_TMO, `SPSC_TMO_DEF);
    rdchk("tper_rst", `SPSC_A_TPER, `SPSC_TPER_DEF);
    apb_x(1'b1, `SPSC_A_CTRL, 2);
    apb_x(1'b1, `SPSC_A_CTRL, 6);
    rdchk("ctrl_keep", `SPSC_A_CTRL, 2);
    apb_x(1'b1, `SPSC_A_CTRL, 8);
    rdchk("ctrl_def", `SPSC_A_CTRL, 5);
    rdchk("unmapped_rd", 8'h1C, 0);
    chk("unmapped_err", perr, 1);
  endtask
  task automatic t_beeps();
    int k;
    logic [15:0] b;
    for (k = 0; k < 2; k++) begin
      b = beeps;
      apb_x(1'b1, `SPSC_A_CMD, k + 1);
      cyc(800 * MS);
      chk("confirm_beeps", beeps - b, 3);
    end
    rdchk("beep_reg", `SPSC_A_BEEP, 32'h34);
    chk("beep_pins", {beep_tone, beep_volume}, 5'h13);
  endtask
  task automatic t_press();
    logic [15:0] b;
    apb_x(1'b1, `SPSC_A_BEEP, 32'h14);
    b = beeps;
    pulse(BTN, 100 * MS);
    cyc(300 * MS);
    chk("short_vol", beep_volume, 2);
    chk("short_beep", beeps - b, 1);
    pulse(BTN, 3100 * MS);
    cyc(10);
    chk("long_off", {motor_on, laser_on}, 0);
    apb_x(1'b0, `SPSC_A_STAT, 0);
    chk("long_state", rd[4:2], 4);
    pulse(BTN, 100 * MS);
    cyc(300 * MS);
    chk("wake_on", {motor_on, laser_on}, 3);
    chk("wake_vol", beep_volume, 2);
  endtask
  task automatic t_zero();
    int k, i, n;
    for (k = ZB; k <= ZR; k++) begin
      n = 0;
      pins[k] <= 1'b1;
      for (i = 0; i < 40; i++) begin
        @(posedge clk);
        n += zero_req;
        if (i == 20) pins[k] <= 1'b0;
      end
      chk("zero_req", n, 1);
    end
    scale_at_zero <= 1'b1;
    cyc(3);
    chk("amber_on", led_amber, 1);
    scale_at_zero <= 1'b0;
    cyc(3);
    chk("amber_off", led_amber, 0);
  endtask
  task automatic t_modes();
    int k;
    int md[3] = '{2, 3, 5};
    int st[3] = '{3, 4, 3};
    apb_x(1'b1, `SPSC_A_TMO, 1);
    for (k = 0; k < 3; k++) begin
      apb_x(1'b1, `SPSC_A_CTRL, md[k]);
      wait_laser(1'b0, 2400 * MS);
      chk("save_motor", {motor_on, laser_on}, k == 1 ? 0 : 2);
      apb_x(1'b0, `SPSC_A_STAT, 0);
      chk("save_state", rd[4:2], st[k]);
      pulse(MOT, 20);
      cyc(10);
      chk("motion_wake", {motor_on, laser_on}, 3);
    end
  endtask
  task automatic t_blink();
    int k, f;
    for (k = 0; k < 2; k++) begin
      apb_x(1'b1, `SPSC_A_CTRL, k == 0 ? 1 : 4);
      wait_laser(1'b0, 2400 * MS);
      laser_flips(1100 * MS, f);
      chk("blink_flips", f >= 2, 1);
      chk("blink_motor", motor_on, 1);
      pulse(MOT, 20);
      cyc(10);
      apb_x(1'b0, `SPSC_A_STAT, 0);
      chk("motion_blink", rd[4:2], k == 0 ? 2 : 1);
      pulse(DEC, 1);
      cyc(10);
      apb_x(1'b0, `SPSC_A_STAT, 0);
      chk("decode_wake", {rd[4:2], laser_on}, 3);
    end
    apb_x(1'b1, `SPSC_A_TMO, `SPSC_TMO_DEF);
  endtask
  task automatic t_selftest();
    int i;
    logic e;
    e = 1'b0;
    fail_next <= 1'b1;
    code_next <= 8'h2A;
    apb_x(1'b1, `SPSC_A_CMD, 4);
    for (i = 0; i < 6000; i++) begin
      @(posedge clk);
      e |= beep_error;
    end
    chk("err_tone", e, 1);
    rdchk("err_code", `SPSC_A_ERR, 32'h2A);
    apb_x(1'b0, `SPSC_A_STAT, 0);
    chk("err_flag", rd[9], 1);
    apb_x(1'b1, `SPSC_A_STAT, 32'h200);
    apb_x(1'b0, `SPSC_A_STAT, 0);
    chk("err_clr", rd[9], 0);
    // A short period starts a test with no command; the next period is
    // at least one second later, after this test has answered.
    code_next <= 8'h15;
    apb_x(1'b1, `SPSC_A_TPER, 2);
    cyc(4000);
    apb_x(1'b1, `SPSC_A_TPER, `SPSC_TPER_DEF);
    rdchk("per_code", `SPSC_A_ERR, 32'h15);
    fail_next <= 1'b0;
  endtask
  // a failed power-up test, from a second reset.
  task automatic t_boot_fail();
    fail_next <= 1'b1;
    code_next <= 8'h33;
    rst_n <= 1'b0;
    cyc(20);
    rst_n <= 1'b1;
    cyc(1);
    chk("rst2_beep", {beep_tone, beep_volume}, 5'h0E);
    while (led_blue !== 1'b1) @(posedge clk);
    cyc(2);
    chk("boot_err_tone", beep_error, 1);
    rdchk("boot_err_code", `SPSC_A_ERR, 32'h33);
    fail_next <= 1'b0;
  endtask
  task automatic t_cal();
    int i, n;
    n = 0;
    pulse(CAL, 1);
    cyc(10);
    pins[BTN] <= 1'b1;
    for (i = 0; i < 400 * MS; i++) begin
      @(posedge clk);
      n += cal_store;
      if (i == 100 * MS) pins[BTN] <= 1'b0;
    end
    chk("cal_store", n, 1);
    chk("cal_point", cal_point, 1);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Main sequence: reset, then every scenario in turn.
  initial begin
    n_fail = 0;
    checks = 0;
    apb = '0;
    pins = '0;
    scale_at_zero = 1'b0;
    fail_next = 1'b0;
    code_next = 8'h00;
    rst_n = 1'b0;
    cyc(20);
    rst_n <= 1'b1;
    cyc(1);
    chk("rst_beep", {beep_tone, beep_volume}, 5'h0E);
    t_start();
    t_regs();
    t_beeps();
    t_press();
    t_zero();
    t_modes();
    t_blink();
    t_selftest();
    t_cal();
    t_boot_fail();
    stop_test();
  end
  // Cuts a hang short well after the expected run length.
  initial begin
    cyc(98000);
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
